// ===== include/rscm_pkg.sv
// constants, carriers and helpers for the reset source recorder and clock monitor
// assumes a byte-wide special-register port driven by the cpu core, one system clock
// What this block does
// - keep a flag register naming the internal source of the latest reset
// - pin reset, power-on clear and any read of the flag register clear it
// - watchdog reset sets its flag, other flags held
// - clock monitor reset sets flag bit 1, other flags held
// - low-voltage reset sets its flag, other flags held
// - low-voltage registers cleared by all resets except the low-voltage one
// - ring oscillator samples crystal input; stopped crystal raises internal reset
// - after any reset the monitor waits for the stabilization period to end
// - monitor idle in stop standby and the stabilization period after it
// - software crystal stop (bit 7 of either register) pauses monitor through stabilization
// - monitor idle while the ring oscillator is not running
// - monitor enable is set-only; cleared solely by reset
// - a monitor reset clears the enable and sets its cause flag
package rscm_pkg;

    localparam int RSCM_DW = 8;

    // byte addresses of the special registers
    localparam logic [15:0] RSCM_ADDR_CAUSE = 16'hFF70;
    localparam logic [15:0] RSCM_ADDR_LVCTL = 16'hFF71;
    localparam logic [15:0] RSCM_ADDR_LVLVL = 16'hFF72;
    localparam logic [15:0] RSCM_ADDR_CLMOD = 16'hFFA9;

    // field positions
    localparam int RSCM_BIT_LOWVOLT = 0;
    localparam int RSCM_BIT_CLOCKMON = 1;
    localparam int RSCM_BIT_WATCHDOG = 2;
    localparam int RSCM_BIT_MON_EN = 0;
    localparam int RSCM_BIT_OSC_STOP = 7;
    localparam int RSCM_BIT_CLK_CUT = 7;

    // reset values
    localparam logic [7:0] RSCM_REG_RESET = 8'h00;
    localparam logic RSCM_EN_RESET = 1'h0;

    // ring ticks without a crystal edge before the crystal counts as stopped
    localparam int RSCM_MISS_W = 3;
    localparam logic [RSCM_MISS_W-1:0] RSCM_MISS_LIMIT = 3'h4;
    localparam logic [RSCM_MISS_W-1:0] RSCM_MISS_ONE = 3'h1;
    localparam logic [RSCM_MISS_W-1:0] RSCM_MISS_ZERO = 3'h0;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [RSCM_DW-1:0] wdata;
    } rscm_sfr_req_t;

    // reset requests from the other sources, one-cycle pulses except pin (level)
    typedef struct packed {
        logic pin;
        logic pwr_on;
        logic wdog;
        logic lowv;
    } rscm_rst_src_t;

    typedef struct packed {
        logic stop_mode;
        logic stab_done;
        logic ring_run;
        logic ring_tick;
        logic xtal;
    } rscm_clk_env_t;

    typedef enum logic [2:0] {
        RSCM_ST_HOLD = 3'h1,
        RSCM_ST_RUN = 3'h2,
        RSCM_ST_FIRE = 3'h4
    } rscm_mon_state_t;

    function automatic logic rscm_hit(input rscm_sfr_req_t r, input logic [15:0] a);
        rscm_hit = (r.addr == a);
    endfunction

endpackage

// ===== rtl/rscm_clock_monitor.sv
// crystal-stop detector sampled on ring oscillator ticks
// assumes ring_tick is a one-cycle enable per ring oscillator period, all inputs synchronous
`timescale 1ns/1ns
module rscm_clock_monitor
    import rscm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic soft_rst,
    input wire logic mon_en,
    input wire logic sw_stop,
    input wire rscm_clk_env_t env,
    // status
    output logic active,
    output logic req
);

    rscm_mon_state_t state_q, state_d;
    logic [RSCM_MISS_W-1:0] miss_q, miss_d;
    logic xtal_prev_q;
    logic seen_q, seen_d;

    wire xtal_edge = env.xtal ^ xtal_prev_q;
    wire pause = soft_rst | env.stop_mode | sw_stop;
    wire heard = seen_q | xtal_edge;
    wire last_miss = (miss_q == RSCM_MISS_LIMIT - RSCM_MISS_ONE);
    // a pause in the same cycle wins, so a fire is never judged and then dropped
    wire stopped = active & ~pause & env.ring_tick & ~heard & last_miss;

    // gate on ring oscillator: without its ticks nothing can be judged
    assign active = (state_q == RSCM_ST_RUN) & mon_en & env.ring_run;
    assign req = (state_q == RSCM_ST_FIRE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            RSCM_ST_HOLD: begin
                if (env.stab_done) begin
                    state_d = RSCM_ST_RUN;
                end
            end
            RSCM_ST_RUN: begin
                if (stopped) begin
                    state_d = RSCM_ST_FIRE;
                end
            end
            RSCM_ST_FIRE: state_d = RSCM_ST_HOLD;
            default: state_d = RSCM_ST_HOLD;
        endcase
        if (pause && state_q != RSCM_ST_FIRE) begin
            state_d = RSCM_ST_HOLD;
        end
    end

    always_comb begin
        seen_d = xtal_edge | (seen_q & ~env.ring_tick);
        miss_d = miss_q;
        if (!active) begin
            miss_d = RSCM_MISS_ZERO;
        end else if (env.ring_tick) begin
            miss_d = heard ? RSCM_MISS_ZERO : miss_q + RSCM_MISS_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= RSCM_ST_HOLD;
            miss_q <= RSCM_MISS_ZERO;
            xtal_prev_q <= 1'h0;
            seen_q <= 1'h0;
        end else begin
            state_q <= state_d;
            miss_q <= miss_d;
            xtal_prev_q <= env.xtal;
            seen_q <= seen_d;
        end
    end

    a_pause_idles: assert property (@(posedge clk) disable iff (!rstn)
        pause |=> !active)
        else $error("monitor active right after a pause condition");

    a_ring_gates: assert property (@(posedge clk) disable iff (!rstn)
        !env.ring_run |-> !active)
        else $error("monitor active with ring oscillator stopped");

    a_hold_to_stab: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == RSCM_ST_HOLD && !env.stab_done) |=> state_q != RSCM_ST_RUN)
        else $error("monitor resumed before stabilization ended");

    a_fire_on_miss: assert property (@(posedge clk) disable iff (!rstn)
        stopped |=> req ##1 !req)
        else $error("crystal stop did not give one request pulse");

endmodule

// ===== rtl/rscm_reset_source.sv
// reset cause recorder, clock monitor mode and low-voltage registers
// assumes the cpu issues byte accesses on SFR_REQ with rd/wr as one-cycle strobes
// and the central reset logic consumes INTERNAL_RESET_REQ
`timescale 1ns/1ns
module rscm_reset_source
    import rscm_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // special-register port
    input wire rscm_sfr_req_t SFR_REQ,
    output logic [RSCM_DW-1:0] SFR_RDATA,
    // reset sources
    input wire rscm_rst_src_t RST_SRC,
    // clock controls owned elsewhere
    input wire logic [RSCM_DW-1:0] MAIN_OSC_CTRL,
    input wire logic [RSCM_DW-1:0] PROC_CLK_CTRL,
    input wire rscm_clk_env_t CLK_ENV,
    // results
    output logic INTERNAL_RESET_REQ,
    output logic CLKMON_ACTIVE,
    output logic [RSCM_DW-1:0] RESET_CAUSE_FLAGS,
    output logic [RSCM_DW-1:0] LOWVOLT_CTRL,
    output logic [RSCM_DW-1:0] LOWVOLT_LEVEL
);

    logic [RSCM_DW-1:0] cause_q, cause_d;
    logic [RSCM_DW-1:0] lvctl_q, lvctl_d;
    logic [RSCM_DW-1:0] lvlvl_q, lvlvl_d;
    logic [RSCM_DW-1:0] rdata_q, rdata_d;
    logic mon_en_q, mon_en_d;
    logic int_rst_q;
    logic mon_req;
    logic mon_active;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_cause = rscm_hit(SFR_REQ, RSCM_ADDR_CAUSE);
    wire hit_lvctl = rscm_hit(SFR_REQ, RSCM_ADDR_LVCTL);
    wire hit_lvlvl = rscm_hit(SFR_REQ, RSCM_ADDR_LVLVL);
    wire hit_clmod = rscm_hit(SFR_REQ, RSCM_ADDR_CLMOD);

    // software is expected to read the flags only as a whole byte;
    // any read of the address is treated as that byte read
    wire rd_cause = SFR_REQ.rd & hit_cause;
    wire wr_lvctl = SFR_REQ.wr & hit_lvctl;
    wire wr_lvlvl = SFR_REQ.wr & hit_lvlvl;
    wire wr_clmod = SFR_REQ.wr & hit_clmod;

    // ------------------------------------------------------------
    // reset source classes
    // ------------------------------------------------------------
    wire ext_clear = RST_SRC.pin | RST_SRC.pwr_on;
    wire any_reset = ext_clear | RST_SRC.wdog | RST_SRC.lowv | mon_req;
    wire lv_clear = ext_clear | RST_SRC.wdog | mon_req;

    wire osc_stop = MAIN_OSC_CTRL[RSCM_BIT_OSC_STOP];
    wire clk_cut = PROC_CLK_CTRL[RSCM_BIT_CLK_CUT];
    wire sw_stop = osc_stop | clk_cut;

    // ------------------------------------------------------------
    // clock monitor
    // ------------------------------------------------------------
    rscm_clock_monitor u_mon (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .soft_rst(any_reset),
        .mon_en(mon_en_q),
        .sw_stop(sw_stop),
        .env(CLK_ENV),
        .active(mon_active),
        .req(mon_req)
    );

    // ------------------------------------------------------------
    // reset cause flags
    // ------------------------------------------------------------
    // a source firing in the same cycle as a read survives the read;
    // pin and power-on clear act as full resets and win over everything
    always_comb begin
        cause_d = cause_q;
        if (rd_cause) begin
            cause_d = RSCM_REG_RESET;
        end
        if (RST_SRC.wdog) begin
            cause_d[RSCM_BIT_WATCHDOG] = 1'h1;
        end
        if (mon_req) begin
            cause_d[RSCM_BIT_CLOCKMON] = 1'h1;
        end
        if (RST_SRC.lowv) begin
            cause_d[RSCM_BIT_LOWVOLT] = 1'h1;
        end
        if (ext_clear) begin
            cause_d = RSCM_REG_RESET;
        end
    end

    // ------------------------------------------------------------
    // clock monitor enable: set-only from software
    // ------------------------------------------------------------
    always_comb begin
        mon_en_d = mon_en_q;
        if (wr_clmod && SFR_REQ.wdata[RSCM_BIT_MON_EN]) begin
            mon_en_d = 1'h1;
        end
        if (any_reset) begin
            mon_en_d = RSCM_EN_RESET;
        end
    end

    // ------------------------------------------------------------
    // low-voltage registers survive their own detector's reset
    // ------------------------------------------------------------
    always_comb begin
        lvctl_d = lvctl_q;
        lvlvl_d = lvlvl_q;
        if (wr_lvctl) begin
            lvctl_d = SFR_REQ.wdata;
        end
        if (wr_lvlvl) begin
            lvlvl_d = SFR_REQ.wdata;
        end
        if (lv_clear) begin
            lvctl_d = RSCM_REG_RESET;
            lvlvl_d = RSCM_REG_RESET;
        end
    end

    // ------------------------------------------------------------
    // read data: captured on the read strobe, held afterwards
    // ------------------------------------------------------------
    wire [RSCM_DW-1:0] clmod_view = {{(RSCM_DW-1){1'h0}}, mon_en_q};

    always_comb begin
        rdata_d = rdata_q;
        if (SFR_REQ.rd) begin
            if (hit_cause) begin
                rdata_d = cause_q;
            end else if (hit_lvctl) begin
                rdata_d = lvctl_q;
            end else if (hit_lvlvl) begin
                rdata_d = lvlvl_q;
            end else if (hit_clmod) begin
                rdata_d = clmod_view;
            end else begin
                rdata_d = RSCM_REG_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cause_q <= RSCM_REG_RESET;
            mon_en_q <= RSCM_EN_RESET;
            lvctl_q <= RSCM_REG_RESET;
            lvlvl_q <= RSCM_REG_RESET;
            rdata_q <= RSCM_REG_RESET;
            int_rst_q <= 1'h0;
        end else begin
            cause_q <= cause_d;
            mon_en_q <= mon_en_d;
            lvctl_q <= lvctl_d;
            lvlvl_q <= lvlvl_d;
            rdata_q <= rdata_d;
            // monitor request joins the other internal sources
            int_rst_q <= RST_SRC.wdog | RST_SRC.lowv | mon_req;
        end
    end

    assign SFR_RDATA = rdata_q;
    assign INTERNAL_RESET_REQ = int_rst_q;
    assign CLKMON_ACTIVE = mon_active;
    assign RESET_CAUSE_FLAGS = cause_q;
    assign LOWVOLT_CTRL = lvctl_q;
    assign LOWVOLT_LEVEL = lvlvl_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    wire only_wdog = RST_SRC.wdog & ~ext_clear & ~mon_req & ~RST_SRC.lowv & ~rd_cause;
    wire only_mon = mon_req & ~ext_clear & ~RST_SRC.wdog & ~RST_SRC.lowv & ~rd_cause;
    wire only_lowv = RST_SRC.lowv & ~ext_clear & ~RST_SRC.wdog & ~mon_req & ~rd_cause;
    wire quiet = ~any_reset & ~rd_cause;

    sequence s_mon_fire;
        mon_req ##1 int_rst_q;
    endsequence

    sequence s_mon_after;
        !mon_en_q && cause_q[RSCM_BIT_CLOCKMON];
    endsequence

    property p_held_flags(logic trig, int keep_a, int keep_b);
        trig |=> (cause_q[keep_a] == $past(cause_q[keep_a]))
            && (cause_q[keep_b] == $past(cause_q[keep_b]));
    endproperty

    a_read_clears: assert property (
        (rd_cause && !RST_SRC.wdog && !RST_SRC.lowv && !mon_req) |=> cause_q == RSCM_REG_RESET)
        else $error("cause flags not cleared by read");

    a_read_returns: assert property (
        rd_cause |=> SFR_RDATA == $past(cause_q))
        else $error("cause read returned wrong value");

    a_pin_clears: assert property (
        ext_clear |=> cause_q == RSCM_REG_RESET && !mon_en_q)
        else $error("pin or power-on reset left state set");

    a_wdog_sets: assert property (
        only_wdog |=> cause_q[RSCM_BIT_WATCHDOG])
        else $error("watchdog flag not set");

    a_wdog_holds: assert property (
        p_held_flags(only_wdog, RSCM_BIT_CLOCKMON, RSCM_BIT_LOWVOLT))
        else $error("watchdog reset disturbed other flags");

    a_mon_holds: assert property (
        p_held_flags(only_mon, RSCM_BIT_WATCHDOG, RSCM_BIT_LOWVOLT))
        else $error("monitor reset disturbed other flags");

    a_lowv_sets: assert property (
        only_lowv |=> cause_q[RSCM_BIT_LOWVOLT]
            && cause_q[RSCM_BIT_WATCHDOG] == $past(cause_q[RSCM_BIT_WATCHDOG]))
        else $error("low-voltage flag wrong");

    a_lv_keeps: assert property (
        (only_lowv && !wr_lvctl && !wr_lvlvl) |=> $stable(lvctl_q) && $stable(lvlvl_q))
        else $error("low-voltage registers lost over own reset");

    a_lv_clears: assert property (
        lv_clear |=> lvctl_q == RSCM_REG_RESET && lvlvl_q == RSCM_REG_RESET)
        else $error("low-voltage registers not cleared");

    a_en_sticky: assert property (
        (mon_en_q && quiet) |=> mon_en_q)
        else $error("monitor enable dropped without reset");

    a_en_set: assert property (
        (wr_clmod && SFR_REQ.wdata[RSCM_BIT_MON_EN] && !any_reset) |=> mon_en_q)
        else $error("monitor enable write ignored");

    a_mon_reset: assert property (
        (mon_req && !ext_clear) |=> s_mon_after)
        else $error("monitor reset did not clear enable and set flag");

    a_mon_forward: assert property (
        mon_req |-> s_mon_fire)
        else $error("monitor request not forwarded");

    a_sw_stop_idle: assert property (
        sw_stop |=> !CLKMON_ACTIVE)
        else $error("monitor active while crystal stopped by software");

    // flags move only on a source or a read; anything else would fake a cause
    a_quiet_keeps: assert property (
        quiet |=> $stable(cause_q))
        else $error("cause flags changed with no source and no read");

    a_fwd_sources: assert property (
        (RST_SRC.wdog || RST_SRC.lowv) |=> INTERNAL_RESET_REQ)
        else $error("watchdog or low-voltage request not forwarded");

    a_no_stray_req: assert property (
        (!RST_SRC.wdog && !RST_SRC.lowv && !mon_req) |=> !INTERNAL_RESET_REQ)
        else $error("internal reset request with no source");

    a_mode_reads: assert property (
        (SFR_REQ.rd && hit_clmod) |=> SFR_RDATA[RSCM_BIT_MON_EN] == $past(mon_en_q)
            && SFR_RDATA[RSCM_DW-1:RSCM_BIT_MON_EN+1] == '0)
        else $error("mode register read wrong");

    // read data must stand until the next read strobe
    a_rdata_holds: assert property (
        !SFR_REQ.rd |=> $stable(SFR_RDATA))
        else $error("read data changed without a read");

    a_lv_written: assert property (
        (wr_lvctl && !lv_clear) |=> lvctl_q == $past(SFR_REQ.wdata))
        else $error("low-voltage control write lost");

    a_lvl_written: assert property (
        (wr_lvlvl && !lv_clear) |=> lvlvl_q == $past(SFR_REQ.wdata))
        else $error("low-voltage level write lost");

    a_en_gates: assert property (
        !mon_en_q |-> !CLKMON_ACTIVE)
        else $error("monitor active while disabled");

    a_stop_idle: assert property (
        CLK_ENV.stop_mode |=> !CLKMON_ACTIVE)
        else $error("monitor active in stop standby");

    a_lowv_clears_en: assert property (
        RST_SRC.lowv |=> !mon_en_q)
        else $error("low-voltage reset left monitor enabled");

endmodule

// ===== testbench/tb.sv
// self-checking bench for the reset source recorder and clock monitor
// assumes the top module alone, driven through its byte register port and source pins
`timescale 1ns/1ns
module tb;
    import rscm_pkg::*;

    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    rscm_sfr_req_t sfr = '0;
    rscm_rst_src_t src = '0;
    rscm_clk_env_t env = '0;
    logic [7:0] osc_ctl = 8'h00;
    logic [7:0] cpu_clk_ctl = 8'h00;
    logic [7:0] rdata;
    logic int_req;
    logic active;
    logic [7:0] flags;
    logic [7:0] lv_ctl;
    logic [7:0] lv_lvl;
    int n_fail = 0;
    int samples_checked = 0;
    int n_req = 0;
    int base;

    always #20 clk_sys = ~clk_sys;

    rscm_reset_source u_dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .SFR_REQ(sfr), .SFR_RDATA(rdata), .RST_SRC(src),
        .MAIN_OSC_CTRL(osc_ctl), .PROC_CLK_CTRL(cpu_clk_ctl), .CLK_ENV(env), .INTERNAL_RESET_REQ(int_req),
        .CLKMON_ACTIVE(active), .RESET_CAUSE_FLAGS(flags), .LOWVOLT_CTRL(lv_ctl), .LOWVOLT_LEVEL(lv_lvl)
    );

    // every internal reset pulse stands one cycle, so counting high samples counts requests
    always @(posedge clk_sys) begin
        if (int_req === 1'h1) begin
            n_req <= n_req + 1;
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic end_test(string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk_sys);
        sfr.addr <= a;
        sfr.wdata <= d;
        sfr.wr <= 1'h1;
        @(posedge clk_sys);
        sfr.wr <= 1'h0;
    endtask

    // always a whole-byte read; the port has no way to ask for a single bit
    task automatic rchk(logic [15:0] a, logic [7:0] exp, string m);
        @(posedge clk_sys);
        sfr.addr <= a;
        sfr.rd <= 1'h1;
        @(posedge clk_sys);
        sfr.rd <= 1'h0;
        #1;
        chk(rdata, exp, m);
    endtask

    task automatic pulse_src(logic [3:0] m);
        @(posedge clk_sys);
        src <= rscm_rst_src_t'(m);
        @(posedge clk_sys);
        src <= '0;
        #1;
    endtask

    task automatic stab();
        @(posedge clk_sys);
        env.stab_done <= 1'h1;
        @(posedge clk_sys);
        env.stab_done <= 1'h0;
        cyc(1);
    endtask

    // toggling xtal twice per tick guarantees an edge between any two ticks
    task automatic ticks(int n, bit toggle);
        repeat (n) begin
            @(posedge clk_sys);
            env.ring_tick <= 1'h1;
            if (toggle) env.xtal <= ~env.xtal;
            @(posedge clk_sys);
            env.ring_tick <= 1'h0;
            if (toggle) env.xtal <= ~env.xtal;
            @(posedge clk_sys);
        end
    endtask

    task automatic set_pause(int k, logic v);
        @(posedge clk_sys);
        case (k)
            0: env.stop_mode <= v;
            1: osc_ctl[RSCM_BIT_OSC_STOP] <= v;
            2: cpu_clk_ctl[RSCM_BIT_CLK_CUT] <= v;
            default: env.ring_run <= ~v;
        endcase
        cyc(2);
    endtask

    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        env.ring_run <= 1'h1;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        cyc(1);

        rchk(RSCM_ADDR_CAUSE, 8'h00, "cause after reset");
        rchk(RSCM_ADDR_LVCTL, 8'h00, "lv ctrl after reset");
        rchk(RSCM_ADDR_LVLVL, 8'h00, "lv level after reset");
        rchk(RSCM_ADDR_CLMOD, 8'h00, "mode after reset");
        rchk(16'hFF73, 8'h00, "unmapped read");
        end_test("reset values");

        wr(RSCM_ADDR_LVCTL, 8'hA5);
        wr(RSCM_ADDR_LVLVL, 8'h3C);
        wr(RSCM_ADDR_CAUSE, 8'hFF);
        rchk(RSCM_ADDR_CAUSE, 8'h00, "cause not writable");
        wr(RSCM_ADDR_CLMOD, 8'hFF);
        wr(RSCM_ADDR_CLMOD, 8'h00);
        rchk(RSCM_ADDR_CLMOD, 8'h01, "enable is set only");
        rchk(RSCM_ADDR_LVLVL, 8'h3C, "lv level readback");
        chk(lv_ctl, 8'hA5, "lv ctrl written");
        end_test("register access");

        pulse_src(4'h2);
        chk({7'h00, int_req}, 8'h01, "watchdog internal request");
        chk(flags, 8'h04, "watchdog flag");
        chk(lv_ctl, 8'h00, "lv ctrl cleared by watchdog");
        rchk(RSCM_ADDR_CLMOD, 8'h00, "enable cleared by internal reset");
        wr(RSCM_ADDR_LVCTL, 8'hA5);
        wr(RSCM_ADDR_LVLVL, 8'h3C);
        pulse_src(4'h1);
        chk({7'h00, int_req}, 8'h01, "low-voltage internal request");
        chk(flags, 8'h05, "low-voltage flag, watchdog held");
        chk(lv_ctl, 8'hA5, "lv ctrl held by low-voltage reset");
        chk(lv_lvl, 8'h3C, "lv level held by low-voltage reset");
        rchk(RSCM_ADDR_CAUSE, 8'h05, "cause read");
        chk(flags, 8'h00, "cleared by read");
        end_test("reset sources");

        pulse_src(4'h3);
        chk(flags, 8'h05, "simultaneous watchdog and low-voltage");
        wr(RSCM_ADDR_CLMOD, 8'h01);
        base = n_req;
        ticks(6, 1'b0);
        chk(active, 8'h00, "idle before stabilization");
        chk(n_req - base, 8'h00, "no fire before stabilization");
        stab();
        chk(active, 8'h01, "active after stabilization");
        ticks(8, 1'b1);
        chk(n_req - base, 8'h00, "running crystal never fires");
        // the first frozen tick still hears the last toggle, so four misses need five ticks
        ticks(4, 1'b0);
        chk(n_req - base, 8'h00, "three misses do not fire");
        ticks(1, 1'b0);
        cyc(4);
        chk(n_req - base, 8'h01, "stopped crystal fires once");
        chk(flags, 8'h07, "clockmon flag, others held");
        rchk(RSCM_ADDR_CLMOD, 8'h00, "enable cleared by monitor");
        chk(active, 8'h00, "idle after firing");
        rchk(RSCM_ADDR_CAUSE, 8'h07, "cause read after monitor");
        end_test("clock monitor");

        wr(RSCM_ADDR_CLMOD, 8'h01);
        stab();
        for (int k = 0; k < 4; k++) begin
            base = n_req;
            set_pause(k, 1'h1);
            chk(active, 8'h00, "paused");
            ticks(5, 1'b0);
            chk(n_req - base, 8'h00, "no fire while paused");
            set_pause(k, 1'h0);
            if (k < 3) begin
                chk(active, 8'h00, "paused through stabilization");
                stab();
            end
            chk(active, 8'h01, "resumed");
        end
        end_test("monitor pauses");

        for (int k = 0; k < 2; k++) begin
            pulse_src(4'h3);
            wr(RSCM_ADDR_LVCTL, 8'h5A);
            wr(RSCM_ADDR_CLMOD, 8'h01);
            pulse_src(k == 0 ? 4'h8 : 4'h4);
            chk(flags, 8'h00, "pin or power-on clear clears cause");
            chk(lv_ctl, 8'h00, "pin or power-on clear clears lv ctrl");
            rchk(RSCM_ADDR_CLMOD, 8'h00, "pin or power-on clear clears enable");
        end
        end_test("pin and power-on clear");

        finish_test();
    end
endmodule
